// File: core/bcml_clk_select.sv
// copy clock enable selection
// assumes crystal ready flag is already synchronised to ref_clk
`timescale 1ns/1ns
`default_nettype none
module bcml_clk_select
	import bcml_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic xtal_ready,
	output logic      copy_en,
	output logic      on_fast_rc
);
	// ----------------------------------------
	// fast rc vs crystal enable
	// ----------------------------------------
	// rc is modelled as a one-in-two enable; crystal gives every cycle
	logic div_reg;
	logic div_next;

	always_comb
	begin
		div_next = ~div_reg;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			div_reg <= 1'b0;
		else
			div_reg <= div_next;
	end

	assign on_fast_rc = ~xtal_ready;
	assign copy_en    = xtal_ready | div_reg;
endmodule
`default_nettype wire

// File: core/bcml_loader.sv
// boot code mirror loader: copies otp or flash image into retention ram
// assumes otp/flash answer reads with a one-cycle valid pulse
//
// Behaviour
// - in normal mode boot or wake copies otp or flash image to ram unaided
// - after copy, start from ram by soft reset or direct branch
// - address zero remaps to the memory holding the code
// - development mode: after code loaded, reset cpu into remapped memory
// - otp copy is clocked by fast rc while crystal settles
// - otp is addressed as 8k words of 64 bits
// - vector table sits at otp offset zero, 64 words long
// - otp mirrors on wake and power-up, flash only on power-up
// - ram is four independently powered cells
// - otp copy length comes from header, in 32-bit words
// - boot-map byte 0xAA selects serial fetch, always starting from FLASH_BASE
`timescale 1ns/1ns
`default_nettype none
module bcml_loader
	import bcml_pkg::*;
(
	input  wire logic                     ref_clk,
	input  wire logic                     reset,
	input  wire logic                     power_up,
	input  wire logic                     wake_up,
	input  wire logic                     dev_mode,
	input  wire logic                     dev_code_loaded,
	input  wire logic                     use_flash,
	input  wire logic                     branch_start,
	input  wire logic                     main_crystal_osc_ready,
	input  wire logic [RAM_CELLS-1:0]     ram_cell_keep,
	output logic                          otp_rd,
	output logic [OTP_ADDR_BITS-1:0]      otp_addr,
	input  wire logic                     otp_valid,
	input  wire logic [OTP_WORD_BITS-1:0] otp_data,
	output logic                          flash_rd,
	output logic [31:0]                   flash_addr,
	output logic                          flash_serial_mode,
	input  wire logic                     flash_valid,
	input  wire logic [31:0]              flash_data,
	output logic                          ram_we,
	output logic [RAM_ADDR_BITS-1:0]      ram_addr,
	output logic [31:0]                   ram_wdata,
	output logic [RAM_CELLS-1:0]          ram_cell_pwr,
	output logic [1:0]                    zero_map_sel,
	output logic                          cpu_hold,
	output logic                          cpu_soft_reset,
	output logic                          cpu_branch,
	output logic                          on_fast_rc,
	output logic                          busy
);
	// ----------------------------------------
	// crystal ready synchroniser, copy enable
	// ----------------------------------------
	logic [2:0] xs_reg;
	logic [2:0] xs_next;
	logic       xtal_ok_reg;
	logic       xtal_ok_next;
	logic       copy_en;

	always_comb
	begin
		xs_next      = {xs_reg[1:0], main_crystal_osc_ready};
		xtal_ok_next = (xs_reg[1] == xs_reg[2]) ? xs_reg[2] : xtal_ok_reg;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			xs_reg      <= 3'h0;
			xtal_ok_reg <= 1'b0;
		end
		else
		begin
			xs_reg      <= xs_next;
			xtal_ok_reg <= xtal_ok_next;
		end
	end

	bcml_clk_select u_clk (
		.ref_clk    (ref_clk),
		.reset      (reset),
		.xtal_ready (xtal_ok_reg),
		.copy_en    (copy_en),
		.on_fast_rc (on_fast_rc)
	);

	// byte address in header to 64-bit word index
	function automatic logic [OTP_ADDR_BITS-1:0] hdr_word(
		input logic [15:0] byte_addr);
		hdr_word = byte_addr[OTP_ADDR_BITS+2:3];
	endfunction

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	bcml_state_e                state_reg;
	bcml_state_e                state_next;
	logic [15:0]                len_reg;
	logic [15:0]                len_next;
	logic [15:0]                cnt_reg;
	logic [15:0]                cnt_next;
	logic [OTP_WORD_BITS-1:0]   buf_reg;
	logic [OTP_WORD_BITS-1:0]   buf_next;
	logic [OTP_ADDR_BITS-1:0]   oa_reg;
	logic [OTP_ADDR_BITS-1:0]   oa_next;
	logic [31:0]                fa_reg;
	logic [31:0]                fa_next;
	logic                       ser_reg;
	logic                       ser_next;
	logic [1:0]                 map_reg;
	logic [1:0]                 map_next;
	logic                       hold_reg;
	logic                       hold_next;
	logic                       srst_reg;
	logic                       srst_next;
	logic                       br_reg;
	logic                       br_next;
	logic                       we_reg;
	logic                       we_next;
	logic [RAM_ADDR_BITS-1:0]   ra_reg;
	logic [RAM_ADDR_BITS-1:0]   ra_next;
	logic [31:0]                wd_reg;
	logic [31:0]                wd_next;
	logic                       pwr_evt;

	assign pwr_evt = power_up | wake_up;

	always_comb
	begin
		state_next = state_reg;
		len_next   = len_reg;
		cnt_next   = cnt_reg;
		buf_next   = buf_reg;
		oa_next    = oa_reg;
		fa_next    = fa_reg;
		ser_next   = ser_reg;
		map_next   = map_reg;
		hold_next  = hold_reg;
		srst_next  = 1'b0;
		br_next    = 1'b0;
		we_next    = 1'b0;
		ra_next    = ra_reg;
		wd_next    = wd_reg;
		case (state_reg)
			BCML_IDLE, BCML_RUN:
			begin
				// from run only a fresh event restarts, else dev loops
				if (dev_mode && dev_code_loaded &&
					(state_reg == BCML_IDLE || pwr_evt))
				begin
					hold_next  = 1'b1;
					map_next   = MAP_RAM;
					state_next = BCML_START;
				end
				else if (power_up && use_flash)
				begin
					hold_next  = 1'b1;
					map_next   = MAP_BOOT_STORE;
					oa_next    = hdr_word(HDR_BOOTMAP_ADDR);
					state_next = BCML_HDR_MAP;
				end
				else if (pwr_evt)
				begin
					hold_next  = 1'b1;
					map_next   = MAP_BOOT_STORE;
					oa_next    = hdr_word(HDR_LEN_ADDR);
					state_next = BCML_HDR_LEN;
				end
			end
			BCML_HDR_LEN:
			begin
				if (otp_valid)
				begin
					len_next   = otp_data[15:0];
					cnt_next   = 16'h0000;
					oa_next    = '0;
					ra_next    = '0;
					state_next = (otp_data[15:0] == 16'h0000) ?
						BCML_REMAP : BCML_OTP_RD;
				end
			end
			BCML_HDR_MAP:
			begin
				if (otp_valid)
				begin
					ser_next = (otp_data[BOOTMAP_SEL_LSB+7:BOOTMAP_SEL_LSB]
						== BOOT_SERIAL_CODE);
					fa_next    = FLASH_BASE;
					cnt_next   = 16'h0000;
					ra_next    = '0;
					state_next = BCML_FL_RD;
				end
			end
			BCML_OTP_RD:
			begin
				if (otp_valid)
				begin
					buf_next   = otp_data;
					state_next = BCML_OTP_WR_LO;
				end
			end
			BCML_OTP_WR_LO:
			begin
				if (copy_en)
				begin
					we_next  = 1'b1;
					wd_next  = buf_reg[31:0];
					cnt_next = cnt_reg + 16'h0001;
					state_next = (cnt_reg + 16'h0001 == len_reg) ?
						BCML_REMAP : BCML_OTP_WR_HI;
				end
			end
			BCML_OTP_WR_HI:
			begin
				if (copy_en)
				begin
					we_next  = 1'b1;
					wd_next  = buf_reg[63:32];
					oa_next  = oa_reg + 1'b1;
					cnt_next = cnt_reg + 16'h0001;
					state_next = (cnt_reg + 16'h0001 == len_reg) ?
						BCML_REMAP : BCML_OTP_RD;
				end
			end
			BCML_FL_RD:
			begin
				if (flash_valid)
				begin
					wd_next    = flash_data;
					state_next = BCML_FL_WR;
				end
			end
			BCML_FL_WR:
			begin
				we_next  = 1'b1;
				fa_next  = fa_reg + 32'h0000_0004;
				cnt_next = cnt_reg + 16'h0001;
				if (cnt_reg == {{(16-RAM_ADDR_BITS){1'b0}},
					{RAM_ADDR_BITS{1'b1}}})
					state_next = BCML_REMAP;
				else
					state_next = BCML_FL_RD;
			end
			BCML_REMAP:
			begin
				map_next   = MAP_RAM;
				state_next = BCML_START;
			end
			BCML_START:
			begin
				// remap registered a cycle earlier, so vectors see ram
				hold_next  = 1'b0;
				srst_next  = ~branch_start | dev_mode;
				br_next    = branch_start & ~dev_mode;
				state_next = BCML_RUN;
			end
			default:
			begin
				state_next = BCML_IDLE;
			end
		endcase
		// step only once a write has been shown, one address per otp half or flash word
		if (we_reg)
			ra_next = ra_reg + 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state_reg <= BCML_IDLE;
			len_reg   <= 16'h0000;
			cnt_reg   <= 16'h0000;
			buf_reg   <= 64'h0;
			oa_reg    <= '0;
			fa_reg    <= 32'h0;
			ser_reg   <= 1'b0;
			map_reg   <= MAP_BOOT_STORE;
			hold_reg  <= 1'b1;
			srst_reg  <= 1'b0;
			br_reg    <= 1'b0;
			we_reg    <= 1'b0;
			ra_reg    <= '0;
			wd_reg    <= 32'h0;
		end
		else
		begin
			state_reg <= state_next;
			len_reg   <= len_next;
			cnt_reg   <= cnt_next;
			buf_reg   <= buf_next;
			oa_reg    <= oa_next;
			fa_reg    <= fa_next;
			ser_reg   <= ser_next;
			map_reg   <= map_next;
			hold_reg  <= hold_next;
			srst_reg  <= srst_next;
			br_reg    <= br_next;
			we_reg    <= we_next;
			ra_reg    <= ra_next;
			wd_reg    <= wd_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign otp_rd      = (state_reg == BCML_HDR_LEN) ||
		(state_reg == BCML_HDR_MAP) || (state_reg == BCML_OTP_RD);
	assign otp_addr    = oa_reg;
	assign flash_rd    = (state_reg == BCML_FL_RD);
	assign flash_addr  = fa_reg;
	assign flash_serial_mode = ser_reg;
	assign ram_we      = we_reg;
	assign ram_addr    = ra_reg;
	assign ram_wdata   = wd_reg;
	// cells forced on while cpu is held (reset, copy, remap); retention choice applies once released
	assign ram_cell_pwr = hold_reg ? {RAM_CELLS{1'b1}} : ram_cell_keep;
	assign zero_map_sel = map_reg;
	assign cpu_hold    = hold_reg;
	assign cpu_soft_reset = srst_reg;
	assign cpu_branch  = br_reg;
	assign busy        = (state_reg != BCML_IDLE) && (state_reg != BCML_RUN);
endmodule
`default_nettype wire

// File: core/bcml_pkg.sv
// boot code mirror loader package: sizes, header offsets, codes
// assumes 64-bit otp words and 32-bit retention ram words
package bcml_pkg;
	// ----------------------------------------
	// storage geometry
	// ----------------------------------------
	localparam int          OTP_WORDS       = 8192;
	localparam int          OTP_WORD_BITS   = 64;
	localparam int          OTP_ADDR_BITS   = 13;
	localparam int          VECTOR_WORDS    = 64;
	localparam int          RAM_CELLS       = 4;
	localparam int          RAM_ADDR_BITS   = 15;
	// ----------------------------------------
	// header byte addresses and codes
	// ----------------------------------------
	localparam logic [15:0] HDR_LEN_ADDR    = 16'hFFF0;
	localparam logic [15:0] HDR_BOOTMAP_ADDR = 16'hFEC0;
	localparam logic [7:0]  BOOT_SERIAL_CODE = 8'hAA;
	localparam int          BOOTMAP_SEL_LSB = 32;
	localparam logic [31:0] FLASH_BASE      = 32'h0000_0000;
	// ----------------------------------------
	// clocking
	// ----------------------------------------
	localparam int          CLK_HZ          = 10_000_000;
	localparam int          RC_OSC_HZ       = 16_000_000;
	// remap selections for address zero
	localparam logic [1:0]  MAP_BOOT_STORE  = 2'h0;
	localparam logic [1:0]  MAP_RAM         = 2'h1;
	localparam logic [1:0]  MAP_OTP         = 2'h2;
	// ----------------------------------------
	// sequencer states
	// ----------------------------------------
	typedef enum logic [3:0] {
		BCML_IDLE,
		BCML_HDR_LEN,
		BCML_HDR_MAP,
		BCML_OTP_RD,
		BCML_OTP_WR_LO,
		BCML_OTP_WR_HI,
		BCML_FL_RD,
		BCML_FL_WR,
		BCML_REMAP,
		BCML_START,
		BCML_RUN
	} bcml_state_e;
endpackage

// File: tb/bcml_loader_assertions.sv
// assertions on the bcml_loader ports
// assumes one clock and a sync active-high reset
`timescale 1ns/1ns
`default_nettype none
module bcml_loader_chk
	import bcml_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic        otp_rd,
	input wire logic [12:0] otp_addr,
	input wire logic        otp_valid,
	input wire logic        flash_rd,
	input wire logic [31:0] flash_addr,
	input wire logic        flash_valid,
	input wire logic        ram_we,
	input wire logic [3:0]  ram_cell_keep,
	input wire logic [3:0]  ram_cell_pwr,
	input wire logic [1:0]  zero_map_sel,
	input wire logic        cpu_hold,
	input wire logic        cpu_soft_reset,
	input wire logic        cpu_branch,
	input wire logic        on_fast_rc
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	chk_map_at_go: assert property ($fell(cpu_hold)
		|-> zero_map_sel == MAP_RAM && $past(zero_map_sel) == MAP_RAM)
		else $error("released before remap");
	chk_go_release: assert property ((cpu_soft_reset || cpu_branch)
		|-> ##[0:1] !cpu_hold) else $error("start without release");
	chk_pulse_once: assert property ((cpu_soft_reset || cpu_branch)
		|=> !(cpu_soft_reset || cpu_branch)) else $error("start too long");
	chk_one_start: assert property (!(cpu_soft_reset && cpu_branch))
		else $error("two start kinds");
	chk_cell_power: assert property (ram_cell_pwr ==
		(cpu_hold ? 4'hF : ram_cell_keep)) else $error("cell power");
	chk_write_held: assert property (ram_we |-> cpu_hold)
		else $error("write while running");
	chk_otp_stands: assert property (otp_rd && !otp_valid
		|=> otp_rd && $stable(otp_addr)) else $error("otp read dropped");
	chk_flash_stands: assert property (flash_rd && !flash_valid
		|=> flash_rd && $stable(flash_addr)) else $error("flash read dropped");
	chk_rc_rate: assert property (ram_we && on_fast_rc
		&& $past(on_fast_rc) |-> !$past(ram_we)) else $error("copy too fast");
endmodule
bind bcml_loader bcml_loader_chk i_bcml_loader_chk (.ref_clk, .reset,
	.otp_rd, .otp_addr, .otp_valid, .flash_rd, .flash_addr, .flash_valid,
	.ram_we, .ram_cell_keep, .ram_cell_pwr, .zero_map_sel, .cpu_hold,
	.cpu_soft_reset, .cpu_branch, .on_fast_rc);
`default_nettype wire

// File: tb/bcml_nv_model.sv
// otp and flash storage answering loader reads
// assumes reads stand until valid; odd word addresses answer slowly
`timescale 1ns/1ns
`default_nettype none
module bcml_nv_model
	import bcml_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        otp_rd,
	input  wire logic [12:0] otp_addr,
	output logic             otp_valid,
	output logic [63:0]      otp_data,
	input  wire logic        flash_rd,
	input  wire logic [31:0] flash_addr,
	output logic             flash_valid,
	output logic [31:0]      flash_data,
	input  wire logic [15:0] len,
	input  wire logic [7:0]  map_byte
);
	int ow, fw;
	function automatic logic [63:0] word(input logic [12:0] a);
		if (a == HDR_LEN_ADDR[15:3])
			return {48'h0, len};
		if (a == HDR_BOOTMAP_ADDR[15:3])
			return {24'h0, map_byte, 32'h0};
		return {16'hC3C3, 3'h0, a, 16'h3C3C, 3'h0, a};
	endfunction
	// released data shows the inverse, so stale reads show up
	always @(posedge ref_clk)
	begin
		if (reset || otp_valid)
		begin
			otp_valid <= 1'b0;
			otp_data <= reset ? 64'h0 : ~otp_data;
			ow <= 0;
		end
		else if (otp_rd)
		begin
			ow <= ow + 1;
			if (ow == (otp_addr[0] ? 2 : 0))
			begin
				ow <= 0;
				otp_valid <= 1'b1;
				otp_data <= word(otp_addr);
			end
		end
		if (reset || flash_valid)
		begin
			flash_valid <= 1'b0;
			flash_data <= reset ? 32'h0 : ~flash_data;
			fw <= 0;
		end
		else if (flash_rd)
		begin
			fw <= fw + 1;
			if (fw == (flash_addr[2] ? 2 : 0))
			begin
				fw <= 0;
				flash_valid <= 1'b1;
				flash_data <= {flash_addr[15:0], ~flash_addr[15:0]};
			end
		end
	end
endmodule
`default_nettype wire

// File: tb/tb.sv
// bench for the boot code mirror loader
// assumes bcml_nv_model stands in for otp and flash
`timescale 1ns/1ns
`default_nettype none
module tb
	import bcml_pkg::*;
;
	logic        ref_clk = 0, reset = 1, power_up = 0, wake_up = 0;
	logic        dev_mode = 0, dev_code_loaded = 0, use_flash = 0;
	logic        branch_start = 0, main_crystal_osc_ready = 0;
	logic [3:0]  ram_cell_keep = 4'h5;
	logic [15:0] len = 16'h0;
	logic [7:0]  map_byte = 8'h0;
	logic        otp_rd, otp_valid, flash_rd, flash_valid, flash_serial_mode;
	logic        ram_we, cpu_hold, cpu_soft_reset, cpu_branch, on_fast_rc;
	logic        busy;
	logic [12:0] otp_addr;
	logic [63:0] otp_data;
	logic [31:0] flash_addr, flash_data, ram_wdata;
	logic [14:0] ram_addr;
	logic [3:0]  ram_cell_pwr;
	logic [1:0]  zero_map_sel;
	logic [46:0] wlog [$];
	int          mismatches = 0, cmp_count = 0, cyc = 0, n_sr, n_br, n_fl;
	bcml_loader i_bcml_loader (.ref_clk, .reset, .power_up, .wake_up,
		.dev_mode, .dev_code_loaded, .use_flash, .branch_start,
		.main_crystal_osc_ready, .ram_cell_keep, .otp_rd, .otp_addr,
		.otp_valid, .otp_data, .flash_rd, .flash_addr, .flash_serial_mode,
		.flash_valid, .flash_data, .ram_we, .ram_addr, .ram_wdata,
		.ram_cell_pwr, .zero_map_sel, .cpu_hold, .cpu_soft_reset,
		.cpu_branch, .on_fast_rc, .busy);
	bcml_nv_model i_bcml_nv_model (.ref_clk, .reset, .otp_rd, .otp_addr,
		.otp_valid, .otp_data, .flash_rd, .flash_addr, .flash_valid,
		.flash_data, .len, .map_byte);
	always #50 ref_clk = ~ref_clk;
	// sampled mid-cycle so registered outputs have settled
	always @(negedge ref_clk)
	begin
		cyc++;
		if (ram_we)
			wlog.push_back({ram_addr, ram_wdata});
		n_sr += cpu_soft_reset;
		n_br += cpu_branch;
		n_fl += flash_rd;
		if (cyc == 20000)
		begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic kick(input logic pu, input logic wu);
		@(posedge ref_clk);
		wlog.delete();
		{n_sr, n_br, n_fl} = 0;
		power_up <= pu;
		wake_up <= wu;
		@(posedge ref_clk);
		power_up <= 1'b0;
		wake_up <= 1'b0;
	endtask
	task automatic boot(input logic pu, input logic wu);
		int n = 0;
		kick(pu, wu);
		repeat (3) @(negedge ref_clk);
		while (cpu_hold && n < 3000)
		begin
			@(negedge ref_clk);
			n++;
		end
		repeat (2) @(negedge ref_clk);
		check(cpu_hold, 1'b0);
	endtask
	// low half then high half of each otp word, one ram index per half
	task automatic check_copy(input int l);
		logic [63:0] w;
		check(wlog.size(), l);
		foreach (wlog[i])
		begin
			w = {16'hC3C3, 3'h0, 13'(i / 2), 16'h3C3C, 3'h0, 13'(i / 2)};
			check(wlog[i], {15'(i), i % 2 ? w[63:32] : w[31:0]});
		end
	endtask
	task automatic wait_fl(input logic [31:0] a);
		int n = 0;
		while (!(flash_rd && flash_addr === a) && n < 500)
		begin
			@(negedge ref_clk);
			n++;
		end
		check(flash_addr, a);
	endtask
	task automatic s_otp_power();
		@(posedge ref_clk);
		len <= 16'h5;
		boot(1'b1, 1'b0);
		check_copy(5);
		check(n_sr, 1);
		check(zero_map_sel, MAP_RAM);
		check(ram_cell_pwr, 4'h5);
		check(on_fast_rc, 1'b1);
		check(busy, 1'b0);
	endtask
	task automatic s_otp_wake();
		@(posedge ref_clk);
		len <= 16'h4;
		main_crystal_osc_ready <= 1'b1;
		use_flash <= 1'b1;
		branch_start <= 1'b1;
		ram_cell_keep <= 4'hA;
		boot(1'b0, 1'b1);
		check_copy(4);
		check(n_fl, 0);
		check({n_br, n_sr}, {32'd1, 32'd0});
		check(ram_cell_pwr, 4'hA);
		check(on_fast_rc, 1'b0);
	endtask
	task automatic s_dev();
		@(posedge ref_clk);
		dev_mode <= 1'b1;
		dev_code_loaded <= 1'b1;
		boot(1'b1, 1'b0);
		check_copy(0);
		check({n_br, n_sr}, {32'd0, 32'd1});
		check(zero_map_sel, MAP_RAM);
		@(posedge ref_clk);
		dev_mode <= 1'b0;
	endtask
	task automatic s_flash();
		for (int k = 0; k < 2; k++)
		begin
			@(posedge ref_clk);
			map_byte <= k ? BOOT_SERIAL_CODE : 8'h00;
			kick(1'b1, 1'b0);
			wait_fl(32'h0);
			check(flash_serial_mode, k[0]);
			check(busy, 1'b1);
			wait_fl(32'h8);
			// the write of the word at 4 was logged on the edge wait_fl stopped on
			@(negedge ref_clk);
			check(wlog[0], {15'h0, 32'h0000FFFF});
			check(wlog[1], {15'h1, 32'h0004FFFB});
			@(posedge ref_clk);
			reset <= 1'b1;
			repeat (3) @(posedge ref_clk);
			reset <= 1'b0;
			@(negedge ref_clk);
			check(cpu_hold, 1'b1);
			check(zero_map_sel, MAP_BOOT_STORE);
			check(ram_cell_pwr, 4'hF);
		end
	endtask
	initial
	begin
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		s_otp_power();
		s_otp_wake();
		s_dev();
		s_flash();
		give_verdict();
	end
endmodule
`default_nettype wire
